/* lbt_slave.sv */
// Slave end: configure, activate and store bit timing services
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "lbt_defs.svh"
module lbt_slave #(
	parameter int MS_CYCLES = `LBT_MS_CYCLES,
	parameter logic [7:0] MFR_ENTRIES = 8'h00
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	lbt_if.slave link,
	input wire logic cfg_mode,
	output logic [3:0] rate_q,
	output logic [3:0] pending_rate_q,
	output logic tx_quiet_q,
	output logic store_req_q,
	input wire logic store_done,
	input wire logic [7:0] store_err
);
	import lbt_pkg::*;
	typedef enum logic [1:0] {LBT_IDLE, LBT_WAIT1, LBT_WAIT2} lbt_act_t;
	// ============================================================
	// Request decode
	lbt_act_t act_q;
	logic [15:0] delay_q;
	logic [15:0] ms_cnt_q;
	logic [31:0] tick_q;
	logic [7:0] cfg_err_d;
	logic take;
	logic rsp_quiet_block;
	assign take = link.req_valid && link.req_id == `LBT_ID_REQ
		&& cfg_mode;
	assign rsp_quiet_block = (act_q == LBT_WAIT2);
	// Result code for a configure request
	always_comb begin
		if (link.req_data[1] == `LBT_TBL_STD) begin
			cfg_err_d = (link.req_data[2] <= `LBT_IDX_MAX) ?
				`LBT_ERR_OK : `LBT_ERR_UNSUP;
		end else if (link.req_data[1] >= `LBT_TBL_MFR_MIN &&
			link.req_data[2] < MFR_ENTRIES) begin
			cfg_err_d = `LBT_ERR_OK;
		end else begin
			cfg_err_d = `LBT_ERR_UNSUP;
		end
	end
	// ============================================================
	// Configured rate, held apart from the stored copy
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pending_rate_q <= 4'h0;
		end else if (take && link.req_data[0] == `LBT_CMD_CFG
			&& cfg_err_d == `LBT_ERR_OK) begin
			pending_rate_q <= link.req_data[2][3:0];
		end
	end
	// ============================================================
	// Activate: two equal delays measured in milliseconds
	// The first delay leaves time for every slave on the bus to take
	// the request before anyone changes its timing; the second keeps
	// this end silent while slower slaves finish their own switch.
	// A delay of zero switches two cycles after the request and ends one cycle later.
	logic act_take;
	logic period_done;
	logic tick_wrap;

	// Activate accepted only from rest; a request during the delays is
	// dropped so that a stray frame cannot restart the countdown
	assign act_take = (act_q == LBT_IDLE) && take
		&& link.req_data[0] == `LBT_CMD_ACT;

	// One delay period is over once the millisecond count reaches it
	assign period_done = (act_q != LBT_IDLE) && (ms_cnt_q >= delay_q);

	// Last clock cycle of one millisecond
	assign tick_wrap = (tick_q == 32'(MS_CYCLES - 1));

	// Sequencer: rest, first delay, second delay
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			act_q <= LBT_IDLE;
		end else begin
			unique case (act_q)
				LBT_IDLE: begin
					if (act_take) begin
						act_q <= LBT_WAIT1;
					end
				end
				LBT_WAIT1: begin
					if (period_done) begin
						act_q <= LBT_WAIT2;
					end
				end
				LBT_WAIT2: begin
					if (period_done) begin
						act_q <= LBT_IDLE;
					end
				end
				default: begin
					act_q <= LBT_IDLE; // Unused code falls back to rest
				end
			endcase
		end
	end

	// Delay value, byte 1 low and byte 2 high, kept for both periods
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			delay_q <= 16'h0000;
		end else if (act_take) begin
			delay_q <= {link.req_data[2], link.req_data[1]};
		end
	end

	// Milliseconds elapsed in the running period
	// Cleared at each period boundary so both periods have one length
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_q <= 16'h0000;
		end else if (act_take || period_done) begin
			ms_cnt_q <= 16'h0000;
		end else if (act_q != LBT_IDLE && tick_wrap) begin
			ms_cnt_q <= ms_cnt_q + 16'h0001;
		end
	end

	// Clock cycles within the running millisecond
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_q <= 32'h0000_0000;
		end else if (act_take || period_done || tick_wrap) begin
			tick_q <= 32'h0000_0000;
		end else if (act_q != LBT_IDLE) begin
			tick_q <= tick_q + 32'h0000_0001;
		end
	end

	// Active rate follows the configured one at the end of the first delay
	// A rate configured later is only used by the next activate
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rate_q <= 4'h0;
		end else if (period_done && act_q == LBT_WAIT1) begin
			rate_q <= pending_rate_q;
		end
	end

	// Transmit silence for the whole second delay
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_quiet_q <= 1'b0;
		end else if (period_done) begin
			tx_quiet_q <= (act_q == LBT_WAIT1);
		end
	end

	// ============================================================
	// Store handshake with the non-volatile memory
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			store_req_q <= 1'b0;
		end else if (store_done) begin
			store_req_q <= 1'b0;
		end else if (take && link.req_data[0] == `LBT_CMD_STORE) begin
			store_req_q <= 1'b1;
		end
	end
	// ============================================================
	// Answer frames; none for activate, none while quiet
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			link.rsp_valid <= 1'b0;
			link.rsp_id <= 11'h000;
			link.rsp_data <= '0;
		end else begin
			link.rsp_valid <= 1'b0;
			if (!rsp_quiet_block && take &&
				link.req_data[0] == `LBT_CMD_CFG) begin
				link.rsp_valid <= 1'b1;
				link.rsp_id <= `LBT_ID_RSP;
				link.rsp_data <= '0;
				link.rsp_data[0] <= `LBT_CMD_CFG;
				link.rsp_data[1] <= cfg_err_d;
			end else if (!rsp_quiet_block && store_req_q && store_done) begin
				link.rsp_valid <= 1'b1;
				link.rsp_id <= `LBT_ID_RSP;
				link.rsp_data <= '0;
				link.rsp_data[0] <= `LBT_CMD_STORE;
				link.rsp_data[1] <= store_err;
			end
		end
	end
endmodule : lbt_slave

/* lbt_defs.svh */
// Constants of the bit timing services: identifiers, commands, codes, times
`ifndef LBT_DEFS_SVH
`define LBT_DEFS_SVH
`define LBT_ID_REQ 11'h7E5
`define LBT_ID_RSP 11'h7E4
`define LBT_CMD_CFG 8'h13
`define LBT_CMD_ACT 8'h15
`define LBT_CMD_STORE 8'h17
`define LBT_ERR_OK 8'h00
`define LBT_ERR_UNSUP 8'h01
`define LBT_ERR_MEDIA 8'h02
`define LBT_ERR_IMPL 8'hFF
`define LBT_TBL_STD 8'h00
`define LBT_TBL_MFR_MIN 8'h80
`define LBT_IDX_MAX 8'h08
`define LBT_CLK_MHZ 200
`define LBT_UNIT_US 1000
`define LBT_MS_CYCLES (`LBT_CLK_MHZ * `LBT_UNIT_US)
`define LBT_REG_CTRL 4'h0
`define LBT_REG_STAT 4'h4
`define LBT_REG_IRQ 4'h8
`define LBT_REG_MASK 4'hC
`endif

/* lbt_pkg.sv */
// Types shared by both ends of the bit timing services
package lbt_pkg;
	typedef logic [7:0] lbt_byte_t;
	typedef lbt_byte_t [7:0] lbt_frame_t;
	typedef logic [3:0] lbt_rate_t;
endpackage : lbt_pkg

/* lbt_if.sv */
// Frame link between the service master and the slave
`timescale 1ns/1ps
interface lbt_if;
	logic req_valid;
	logic [10:0] req_id;
	lbt_pkg::lbt_frame_t req_data;
	logic rsp_valid;
	logic [10:0] rsp_id;
	lbt_pkg::lbt_frame_t rsp_data;
	modport master (output req_valid, req_id, req_data,
		input rsp_valid, rsp_id, rsp_data);
	modport slave (input req_valid, req_id, req_data,
		output rsp_valid, rsp_id, rsp_data);
endinterface : lbt_if

/* lbt_master.sv */
// Master end: Avalon-MM registers that issue the three services
`timescale 1ns/1ps
`include "lbt_defs.svh"
module lbt_master (
	input wire logic ref_clk,
	input wire logic rst_n,
	lbt_if.master link,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq_q
);
	import lbt_pkg::*;
	logic [1:0] stat_q;
	logic [1:0] mask_q;
	logic [23:0] last_rsp_q;
	logic rsp_ev;
	logic [1:0] ev;
	assign rsp_ev = link.rsp_valid && link.rsp_id == `LBT_ID_RSP;
	assign ev = {1'b0, rsp_ev};
	// ============================================================
	// Bus slave: one wait cycle, then answer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			unique case (avs_address)
				`LBT_REG_STAT: avs_readdata <= {8'h00, last_rsp_q};
				`LBT_REG_IRQ: avs_readdata <= {30'h0, stat_q};
				`LBT_REG_MASK: avs_readdata <= {30'h0, mask_q};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end
	// Request issue: write to control sends a frame, bytes 0..2 in data
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			link.req_valid <= 1'b0;
			link.req_id <= 11'h000;
			link.req_data <= '0;
		end else begin
			link.req_valid <= 1'b0;
			if (avs_write && !avs_waitrequest &&
				avs_address == `LBT_REG_CTRL) begin
				link.req_valid <= 1'b1;
				link.req_id <= `LBT_ID_REQ;
				link.req_data <= {40'h0, avs_writedata[23:0]};
			end
		end
	end
	// Last answer frame kept and the answer event flag
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_rsp_q <= 24'h000000;
			stat_q <= 2'b00;
			mask_q <= 2'b00;
			irq_q <= 1'b0;
		end else begin
			if (rsp_ev) begin
				last_rsp_q <= {link.rsp_data[2], link.rsp_data[1],
					link.rsp_data[0]};
			end
			if (avs_write && !avs_waitrequest &&
				avs_address == `LBT_REG_IRQ) begin
				stat_q <= (stat_q & ~avs_writedata[1:0]) | ev;
			end else begin
				stat_q <= stat_q | ev;
			end
			if (avs_write && !avs_waitrequest &&
				avs_address == `LBT_REG_MASK) begin
				mask_q <= avs_writedata[1:0];
			end
			irq_q <= |(stat_q & mask_q);
		end
	end
endmodule : lbt_master

/* lbt_asserts.sv */
// Checker of frame relations on the link between the two ends
`timescale 1ns/1ps
module lbt_asserts (
	input logic ref_clk,
	input logic rst_n,
	input logic req_valid,
	input logic [10:0] req_id,
	input lbt_pkg::lbt_frame_t req_data,
	input logic rsp_valid,
	input logic [10:0] rsp_id,
	input lbt_pkg::lbt_frame_t rsp_data
);
	import lbt_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// Frame relations
	sequence s_cfg;
		req_valid && req_data[0] == 8'h13;
	endsequence
	property p_req;
		req_valid |-> req_id == 11'h7E5 && req_data[7:3] == 40'h0;
	endproperty
	a_req: assert property (p_req) else $error("bad request");
	property p_rsp;
		rsp_valid |-> rsp_id == 11'h7E4 && rsp_data[7:3] == 40'h0;
	endproperty
	a_rsp: assert property (p_rsp) else $error("bad answer");
	property p_one;
		rsp_valid |=> !rsp_valid;
	endproperty
	a_one: assert property (p_one) else $error("long answer");
	property p_cause;
		rsp_valid && rsp_data[0] == 8'h13 |-> $past(req_valid);
	endproperty
	a_cause: assert property (p_cause) else $error("no cause");
	property p_std;
		s_cfg ##0 (req_data[1] == 8'h00 && req_data[2] <= 8'h08)
			|=> !rsp_valid || rsp_data[1] == 8'h00;
	endproperty
	a_std: assert property (p_std) else $error("std refused");
	property p_rsv;
		s_cfg ##0 (req_data[1] != 8'h00)
			|=> !rsp_valid || rsp_data[1] == 8'h01;
	endproperty
	a_rsv: assert property (p_rsv) else $error("bad code");
	property p_act;
		req_valid && req_data[0] == 8'h15 |=> !rsp_valid [*2];
	endproperty
	a_act: assert property (p_act) else $error("activate answered");
	property p_sto;
		rsp_valid && rsp_data[0] == 8'h17
			|-> rsp_data[1] inside {8'h00, 8'h01, 8'h02, 8'hFF};
	endproperty
	a_sto: assert property (p_sto) else $error("bad store code");
endmodule : lbt_asserts

/* lbt_bench.sv */
// Bench: both ends joined, services driven over the register bus
`timescale 1ns/1ps
module lbt_bench;
	logic ref_clk = 0, rst_n = 0, cfg_mode = 1, store_done = 0;
	logic avs_read = 0, avs_write = 0, avs_waitrequest, irq_q;
	logic tx_quiet_q, store_req_q;
	logic [7:0] store_err = 0, sel, idx, code;
	logic [3:0] avs_address = 0, rate_q, pending_rate_q, want = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, seed = 32'h0B15, r;
	int n_errors = 0, checked = 0;
	lbt_if lnk();
	lbt_master lbt_master_i (.ref_clk, .rst_n, .link(lnk), .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .irq_q);
	lbt_slave #(.MS_CYCLES(4)) lbt_slave_i (.ref_clk, .rst_n, .link(lnk),
		.cfg_mode, .rate_q, .pending_rate_q, .tx_quiet_q, .store_req_q,
		.store_done, .store_err);
	lbt_asserts lbt_asserts_i (.ref_clk, .rst_n, .req_valid(lnk.req_valid),
		.req_id(lnk.req_id), .req_data(lnk.req_data),
		.rsp_valid(lnk.rsp_valid), .rsp_id(lnk.rsp_id),
		.rsp_data(lnk.rsp_data));
	// ==========
	// Helpers
	function logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs
	function logic [7:0] exp_code(input logic [7:0] s, i);
		return (s == 8'h00 && i <= 8'h08) ? 8'h00 : 8'h01;
	endfunction : exp_code
	task chk(input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	// Holds the request until waitrequest is seen low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge ref_clk);
		while (avs_waitrequest) @(posedge ref_clk);
		r = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		repeat (4) @(posedge ref_clk);
	endtask : bus
	task rd(input logic [3:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk(r, e);
	endtask : rd
	task print_verdict;
		if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	initial forever #2.5 ref_clk = ~ref_clk;
	initial begin
		#100000;
		n_errors++;
		print_verdict();
	end
	// ==========
	// Main sequence
	initial begin
		repeat (4) @(posedge ref_clk);
		chk({avs_waitrequest, irq_q, rate_q}, 32'h20);
		rst_n <= 1;
		@(posedge ref_clk);
		bus(1, 4'hC, 1);
		for (int i = 0; i < 20; i++) begin
			sel = i < 9 ? 8'h00 : xs();
			idx = i < 9 ? 8'(i) : xs();
			code = exp_code(sel, idx);
			if (code === 8'h00) want = idx[3:0];
			bus(1, 4'h0, {8'h00, idx, sel, 8'h13});
			rd(4'h4, {16'h0000, code, 8'h13});
			chk({pending_rate_q, store_req_q, irq_q}, {want, 2'b01});
			bus(1, 4'h8, 1);
			chk(irq_q, 0);
		end
		bus(1, 4'hC, 0);
		bus(1, 4'h0, 32'h030013);
		want = 3;
		chk(irq_q, 0);
		rd(4'h8, 1);
		bus(1, 4'h8, 1);
		cfg_mode <= 0;
		bus(1, 4'h0, 32'h050013);
		chk(pending_rate_q, want);
		rd(4'h8, 0);
		cfg_mode <= 1;
		bus(1, 4'hC, 1);
		bus(1, 4'h0, 32'h000415);
		chk(rate_q, 0);
		repeat (18) @(posedge ref_clk);
		chk({rate_q, tx_quiet_q}, {want, 1'b1});
		repeat (18) @(posedge ref_clk);
		chk(tx_quiet_q, 0);
		rd(4'h8, 0);
		for (int i = 0; i < 4; i++) begin
			code = i == 3 ? 8'hFF : 8'(i);
			bus(1, 4'h0, 32'h17);
			chk(store_req_q, 1);
			store_err <= code;
			store_done <= 1;
			@(posedge ref_clk);
			store_done <= 0;
			repeat (4) @(posedge ref_clk);
			rd(4'h4, {16'h0000, code, 8'h17});
		end
		print_verdict();
	end
endmodule : lbt_bench
